//--- rtl/flash_isp_pkg.sv
// Constants, register map and carriers for the flash programming sequencer.
package flash_isp_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_ADDRESS  = 8'h04;
  localparam logic [7:0] OFS_DATA     = 8'h08;
  localparam logic [7:0] OFS_COMMAND  = 8'h0c;
  localparam logic [7:0] OFS_TRIGGER  = 8'h10;
  localparam logic [7:0] OFS_DR_BASE  = 8'h14;
  localparam logic [7:0] OFS_TIMING   = 8'h18;
  localparam logic [7:0] OFS_UNLOCK   = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_PROG_EN  = 0;
  localparam int CTL_BOOT_SEL = 1;
  localparam int CTL_APP_UEN  = 3;
  localparam int CTL_CFG_UEN  = 4;
  localparam int CTL_LDR_UEN  = 5;
  localparam int CTL_FAIL     = 6;
  localparam int TIM_LOW_OPT  = 4;
  localparam int TIM_MID_OPT  = 6;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_FAIL     = 1;
  localparam int ADR_CFG_HI   = 21;
  localparam int ADR_CFG_LO   = 20;
  localparam int ADR_LDR_BIT  = 20;

  localparam logic [31:0] CTL_WMASK  = 32'h0000_003b;
  localparam logic [31:0] TIM_WMASK  = 32'h0000_0050;
  localparam logic [31:0] ERASE_WORD = 32'hffff_ffff;
  localparam logic [31:0] DR_FIXED   = 32'h0001_f000;
  localparam logic [31:0] UID_LAST   = 32'h0000_0008;
  localparam logic [31:0] ADDR_LIMIT = 32'h0010_0000;
  localparam logic [31:0] CFG_LIMIT  = 32'h0000_0008;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  localparam logic [31:0] CFG_SEL    = 32'h0030_0000;
  localparam logic [31:0] MAIN_LIMIT = 32'h0020_0000;

  // ---------------------------------------------------------------
  // Unlock keys and command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] KEY1 = 8'h59;
  localparam logic [7:0] KEY2 = 8'h16;
  localparam logic [7:0] KEY3 = 8'h88;
  localparam logic [3:0] FN_READ  = 4'h0;
  localparam logic [3:0] FN_PROG  = 4'h1;
  localparam logic [3:0] FN_ERASE = 4'h2;
  localparam logic [3:0] FN_UID   = 4'h4;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ       = 200;
  localparam int ARRAY_OP_NS   = 40;
  localparam int ARRAY_OP_CYC  = (ARRAY_OP_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } seq_state_t;

  typedef struct packed {
    logic       op_en;
    logic       chip_en;
    logic [3:0] func;
  } isp_cmd_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        erase;
    logic        uid;
    logic        cfg;
    logic [31:0] addr;
    logic [31:0] wdata;
  } array_req_t;
endpackage

//--- rtl/flash_isp_sequencer.sv
// Flash in-system programming sequencer with an APB register slave.
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
module flash_isp_sequencer #(
  parameter int OP_CYCLES = flash_isp_pkg::ARRAY_OP_CYC
) (
  input  wire logic                      CLOCK,
  input  wire logic                      RST,
  input  wire logic                      PSEL,
  input  wire logic                      PENABLE,
  input  wire logic                      PWRITE,
  input  wire logic [7:0]                PADDR,
  input  wire logic [31:0]               PWDATA,
  output logic      [31:0]               PRDATA,
  output logic                           PREADY,
  output logic                           PSLVERR,
  input  wire logic [1:0]                BOOT_CONFIG_FIELD,
  input  wire logic                      DATA_REGION_FIXED_SIZE,
  input  wire logic [31:0]               CONFIG_WORD1,
  input  wire logic                      WARM_RESET,
  input  wire logic                      RUNNING_FROM_LOADER,
  input  wire logic [31:0]               ARRAY_RDATA,
  output flash_isp_pkg::array_req_t      ARRAY_REQ,
  output logic                           CPU_STALL,
  output logic                           IRQ
);
  import flash_isp_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [31:0] control_r;
  logic [31:0] address_r;
  logic [31:0] data_r;
  isp_cmd_t    cmd_r;
  logic        trigger_r;
  logic [31:0] timing_r;
  logic [31:0] dr_base_r;
  logic [1:0]  unlock_r;
  logic        unlocked_r;
  logic [1:0]  irq_stat_r;
  logic [1:0]  irq_mask_r;
  logic [15:0] count_r;
  seq_state_t  state_r;
  logic        cfg_ok_r;
  logic [1:0]  boot_cfg_s1_r;
  logic [1:0]  boot_cfg_s2_r;
  logic        fixed_s1_r;
  logic        fixed_s2_r;
  logic        warm_s1_r;
  logic        warm_s2_r;
  logic        ldr_s1_r;
  logic        ldr_s2_r;

  logic        wr_acc;
  logic        go_req;
  logic        fail_now;
  logic        done_now;
  logic        tgt_cfg;
  logic        tgt_ldr;
  logic        is_write;
  logic        bad_addr;
  logic        bad_cmd;
  logic [31:0] rdata_nxt;

  assign wr_acc = PSEL && PENABLE && PWRITE && PREADY;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    boot_cfg_s1_r <= BOOT_CONFIG_FIELD;
    boot_cfg_s2_r <= boot_cfg_s1_r;
    fixed_s1_r    <= DATA_REGION_FIXED_SIZE;
    fixed_s2_r    <= fixed_s1_r;
    warm_s1_r     <= WARM_RESET;
    warm_s2_r     <= warm_s1_r;
    ldr_s1_r      <= RUNNING_FROM_LOADER;
    ldr_s2_r      <= ldr_s1_r;
  end

  // ---------------------------------------------------------------
  // Unlock sequence
  // ---------------------------------------------------------------
  // Any write that breaks the key order restarts the search.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      unlock_r   <= 2'h0;
      unlocked_r <= 1'b0;
    end
    else if (wr_acc && PADDR == OFS_UNLOCK)
    begin
      unlocked_r <= 1'b0;
      if (unlock_r == 2'h0 && PWDATA[7:0] == KEY1)
        unlock_r <= 2'h1;
      else if (unlock_r == 2'h1 && PWDATA[7:0] == KEY2)
        unlock_r <= 2'h2;
      else if (unlock_r == 2'h2 && PWDATA[7:0] == KEY3)
      begin
        unlock_r   <= 2'h0;
        unlocked_r <= 1'b1;
      end
      else
        unlock_r <= 2'h0;
    end
  end

  // ---------------------------------------------------------------
  // Trigger checks
  // ---------------------------------------------------------------
  assign is_write = cmd_r.op_en;
  assign tgt_cfg  = address_r[ADR_CFG_HI] && address_r[ADR_CFG_LO];
  assign tgt_ldr  = !address_r[ADR_CFG_HI] && address_r[ADR_LDR_BIT];
  assign bad_cmd  = cmd_r.chip_en
                    || !((cmd_r.func == FN_READ && !cmd_r.op_en)
                      || (cmd_r.func == FN_PROG && cmd_r.op_en)
                      || (cmd_r.func == FN_ERASE && cmd_r.op_en)
                      || (cmd_r.func == FN_UID && !cmd_r.op_en));
  assign bad_addr = (cmd_r.func == FN_UID)
                    ? (address_r > UID_LAST)
                    : (tgt_cfg ? ((address_r & ~CFG_SEL) > CFG_LIMIT)
                               : (address_r >= MAIN_LIMIT || address_r[ADR_CFG_HI]));
  assign go_req   = wr_acc && PADDR == OFS_TRIGGER && PWDATA[0] && state_r == ST_IDLE;
  assign fail_now = go_req && (!control_r[CTL_PROG_EN] || bad_cmd || bad_addr
                    || (is_write && tgt_cfg && !control_r[CTL_CFG_UEN])
                    || (is_write && tgt_ldr && ldr_s2_r && !control_r[CTL_LDR_UEN])
                    || (is_write && !tgt_cfg && !tgt_ldr && !ldr_s2_r
                        && !control_r[CTL_APP_UEN]));
  assign done_now = state_r == ST_DONE;

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      control_r <= ZERO_WORD;
      // Boot select survives reset; the release below reloads it unless warm.
      control_r[CTL_BOOT_SEL] <= control_r[CTL_BOOT_SEL];
      cfg_ok_r  <= 1'b0;
    end
    else
    begin
      if (!cfg_ok_r)
      begin
        cfg_ok_r <= 1'b1;
        if (!warm_s2_r)
          control_r[CTL_BOOT_SEL] <= ~boot_cfg_s2_r[1];
      end
      else if (wr_acc && PADDR == OFS_CONTROL && unlocked_r)
        control_r <= (control_r & ~CTL_WMASK) | (PWDATA & CTL_WMASK);
      if (fail_now)
        control_r[CTL_FAIL] <= 1'b1;
      else if (wr_acc && PADDR == OFS_CONTROL && unlocked_r && PWDATA[CTL_FAIL])
        control_r[CTL_FAIL] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Address, command and timing registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      address_r <= ZERO_WORD;
      cmd_r     <= '0;
      timing_r  <= ZERO_WORD;
    end
    else if (wr_acc && state_r == ST_IDLE)
    begin
      if (PADDR == OFS_ADDRESS)
        address_r <= PWDATA;
      if (PADDR == OFS_COMMAND)
        cmd_r <= PWDATA[5:0];
      if (PADDR == OFS_TIMING && unlocked_r)
        timing_r <= PWDATA & TIM_WMASK;
    end
  end

  // ---------------------------------------------------------------
  // Data register
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      data_r <= ZERO_WORD;
    else if (done_now && !cmd_r.op_en)
      data_r <= ARRAY_RDATA;
    else if (wr_acc && PADDR == OFS_DATA && state_r == ST_IDLE)
      data_r <= PWDATA;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // The CPU stall covers the whole run so that software cannot alter
  // the operands mid-operation.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      state_r   <= ST_IDLE;
      trigger_r <= 1'b0;
      count_r   <= 16'h0;
      ARRAY_REQ <= '0;
      CPU_STALL <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (go_req && !fail_now)
          begin
            state_r         <= ST_RUN;
            trigger_r       <= 1'b1;
            CPU_STALL       <= 1'b1;
            count_r         <= 16'(OP_CYCLES);
            ARRAY_REQ.req   <= 1'b1;
            ARRAY_REQ.write <= cmd_r.op_en;
            ARRAY_REQ.erase <= cmd_r.func == FN_ERASE;
            ARRAY_REQ.uid   <= cmd_r.func == FN_UID;
            ARRAY_REQ.cfg   <= tgt_cfg;
            ARRAY_REQ.addr  <= address_r;
            ARRAY_REQ.wdata <= (cmd_r.func == FN_ERASE) ? ERASE_WORD : data_r;
          end
        end
        ST_RUN:
        begin
          ARRAY_REQ.req <= 1'b0;
          if (count_r <= 16'h1)
            state_r <= ST_DONE;
          else
            count_r <= count_r - 16'h1;
        end
        ST_DONE:
        begin
          state_r   <= ST_IDLE;
          trigger_r <= 1'b0;
          CPU_STALL <= 1'b0;
        end
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Data region base
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
      dr_base_r <= DR_FIXED;
    else
      dr_base_r <= fixed_s2_r ? DR_FIXED : CONFIG_WORD1;
  end

  // ---------------------------------------------------------------
  // Interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      irq_stat_r <= 2'h0;
      irq_mask_r <= 2'h0;
      IRQ        <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        if ((i == IRQ_DONE && done_now) || (i == IRQ_FAIL && fail_now))
          irq_stat_r[i] <= 1'b1;
        else if (wr_acc && PADDR == OFS_IRQ_STAT && PWDATA[i])
          irq_stat_r[i] <= 1'b0;
      end
      if (wr_acc && PADDR == OFS_IRQ_MASK)
        irq_mask_r <= PWDATA[1:0];
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  always_comb
  begin
    unique case (PADDR)
      OFS_CONTROL:  rdata_nxt = control_r;
      OFS_ADDRESS:  rdata_nxt = address_r;
      OFS_DATA:     rdata_nxt = data_r;
      OFS_COMMAND:  rdata_nxt = {26'h0, cmd_r};
      OFS_TRIGGER:  rdata_nxt = {31'h0, trigger_r};
      OFS_DR_BASE:  rdata_nxt = dr_base_r;
      OFS_TIMING:   rdata_nxt = timing_r;
      OFS_IRQ_STAT: rdata_nxt = {30'h0, irq_stat_r};
      OFS_IRQ_MASK: rdata_nxt = {30'h0, irq_mask_r};
      default:      rdata_nxt = ZERO_WORD;
    endcase
  end

  // No wait state: PREADY rises in the first access cycle.
  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= ZERO_WORD;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && (PADDR[1:0] != 2'h0 || PADDR > OFS_IRQ_MASK);
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= rdata_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_fail_blocks;
    @(posedge CLOCK) disable iff (RST)
    fail_now |=> control_r[CTL_FAIL] && !trigger_r;
  endproperty
  a_fail_blocks: assert property (p_fail_blocks) else $error("fail did not block");
  property p_trig_clears;
    @(posedge CLOCK) disable iff (RST)
    $rose(trigger_r) |-> ##[1:1000] $fell(trigger_r);
  endproperty
  a_trig_clears: assert property (p_trig_clears) else $error("trigger stuck");
  property p_stall_follows;
    @(posedge CLOCK) disable iff (RST)
    CPU_STALL == trigger_r;
  endproperty
  a_stall_follows: assert property (p_stall_follows) else $error("stall mismatch");
  property p_locked;
    @(posedge CLOCK) disable iff (RST)
    (!unlocked_r && cfg_ok_r && !fail_now) |=> $stable(control_r[5:0]);
  endproperty
  a_locked: assert property (p_locked) else $error("locked write took");
  property p_erase_ones;
    @(posedge CLOCK) disable iff (RST)
    $rose(ARRAY_REQ.req) && ARRAY_REQ.erase |-> ARRAY_REQ.wdata == ERASE_WORD;
  endproperty
  a_erase_ones: assert property (p_erase_ones) else $error("erase data wrong");
  property p_base;
    @(posedge CLOCK) disable iff (RST)
    fixed_s2_r |=> dr_base_r == DR_FIXED;
  endproperty
  a_base: assert property (p_base) else $error("base not fixed");
  property p_cfg_protect;
    @(posedge CLOCK) disable iff (RST)
    go_req && cmd_r.op_en && tgt_cfg && !control_r[CTL_CFG_UEN]
      |=> control_r[CTL_FAIL] && state_r == ST_IDLE;
  endproperty
  a_cfg_protect: assert property (p_cfg_protect) else $error("config write allowed");
  property p_fail_sticky;
    @(posedge CLOCK) disable iff (RST)
    control_r[CTL_FAIL] && !wr_acc |=> control_r[CTL_FAIL];
  endproperty
  a_fail_sticky: assert property (p_fail_sticky) else $error("fail lost");
endmodule

//--- test/flash_array_model.sv
// Behavioural flash array that answers the sequencer's array requests.
`timescale 1ns/1ps
module flash_array_model #(
  parameter logic [31:0] UID_SEED = 32'h1357_9bdf // Arbitrary value.
) (
  input  wire logic                 CLOCK,
  input  flash_isp_pkg::array_req_t REQ,
  output logic [31:0]               RDATA
);
  import flash_isp_pkg::*;
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [31:0] main_mem [0:63];
  logic [31:0] cfg_mem  [0:3];

  initial
  begin
    foreach (main_mem[i])
      main_mem[i] = ERASE_WORD;
    foreach (cfg_mem[i])
      cfg_mem[i] = ERASE_WORD;
    RDATA = ZERO_WORD;
  end

  // ---------------------------------------------------------------
  // Request handling
  // ---------------------------------------------------------------
  // Erase stores the data word the sequencer sends, so a wrong word shows up.
  always @(posedge CLOCK)
  begin
    if (REQ.req)
    begin
      if (REQ.uid)
        RDATA <= UID_SEED + REQ.addr;
      else if (REQ.write | REQ.erase)
      begin
        if (REQ.cfg)
          cfg_mem[REQ.addr[3:2]] <= REQ.wdata;
        else
          main_mem[REQ.addr[7:2]] <= REQ.wdata;
        RDATA <= ~RDATA;
      end
      else
        RDATA <= REQ.cfg ? cfg_mem[REQ.addr[3:2]] : main_mem[REQ.addr[7:2]];
    end
  end
endmodule

//--- test/flash_isp_sequencer_test.sv
// Self-checking bench for the flash programming sequencer.
`timescale 1ns/1ps
module flash_isp_sequencer_test;
  import flash_isp_pkg::*;
  localparam logic [31:0] UID_SEED = 32'h1357_9bdf; // Arbitrary value.
  logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, CONFIG_WORD1, ARRAY_RDATA, rd_q;
  logic [1:0]  BOOT_CONFIG_FIELD;
  logic DATA_REGION_FIXED_SIZE, WARM_RESET, RUNNING_FROM_LOADER, CPU_STALL, IRQ, er_q;
  array_req_t  ARRAY_REQ;
  int err_count = 0;
  int n_tests = 0;

  flash_isp_sequencer #(.OP_CYCLES(8)) u_flash_isp_sequencer (
    .CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .BOOT_CONFIG_FIELD(BOOT_CONFIG_FIELD),
    .DATA_REGION_FIXED_SIZE(DATA_REGION_FIXED_SIZE), .CONFIG_WORD1(CONFIG_WORD1),
    .WARM_RESET(WARM_RESET), .RUNNING_FROM_LOADER(RUNNING_FROM_LOADER),
    .ARRAY_RDATA(ARRAY_RDATA), .ARRAY_REQ(ARRAY_REQ), .CPU_STALL(CPU_STALL), .IRQ(IRQ));

  flash_array_model #(.UID_SEED(UID_SEED)) u_flash_array_model (
    .CLOCK(CLOCK), .REQ(ARRAY_REQ), .RDATA(ARRAY_RDATA));

  // ---------------------------------------------------------------
  // Clock, checks and bus tasks
  // ---------------------------------------------------------------
  initial
  begin
    CLOCK = 1'b0;
    forever #2.5 CLOCK = ~CLOCK;
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Holds the request until PREADY is sampled high, then takes the answer.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do
      @(posedge CLOCK);
    while (PREADY !== 1'b1);
    rd_q = PRDATA;
    er_q = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, ZERO_WORD);
    chk(nm, rd_q, e);
  endtask

  task automatic unlock();
    apb(1'b1, OFS_UNLOCK, {24'h0, KEY1});
    apb(1'b1, OFS_UNLOCK, {24'h0, KEY2});
    apb(1'b1, OFS_UNLOCK, {24'h0, KEY3});
  endtask

  task automatic reset_dut();
    RST <= 1'b1;
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
  endtask

  task automatic settle();
    repeat (2) @(posedge CLOCK);
    #1;
  endtask

  function automatic logic [31:0] cmdw(input logic oe, input logic [3:0] fn);
    return {26'h0, oe, 1'b0, fn};
  endfunction

  // A refused trigger must leave the CPU running and the trigger at zero.
  task automatic run_op(input logic [31:0] cmd, input logic [31:0] a, input logic [31:0] d,
                        input logic failop);
    int n;
    apb(1'b1, OFS_ADDRESS, a);
    apb(1'b1, OFS_DATA, d);
    apb(1'b1, OFS_COMMAND, cmd);
    apb(1'b1, OFS_TRIGGER, 32'h0000_0001);
    @(posedge CLOCK);
    #1;
    chk("stall", {31'h0, CPU_STALL}, {31'h0, !failop});
    n = 0;
    do
    begin
      apb(1'b0, OFS_TRIGGER, ZERO_WORD);
      if (n == 0)
        chk("trigger busy", rd_q, {31'h0, !failop});
      n++;
    end
    while (rd_q[0] !== 1'b0 && n < 30);
    chk("trigger done", rd_q, ZERO_WORD);
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  logic [31:0] rst_val [0:6] = '{0, 0, 0, 0, 0, DR_FIXED, 0};
  logic [31:0] bad_ctl [0:3] = '{32'h31, 32'h29, 32'h19, 32'h39};
  logic [31:0] bad_adr [0:3] = '{32'h100, 32'h0030_0000, 32'h0010_0000, 32'h0020_0000};

  initial
  begin
    {PSEL, PENABLE, PWRITE, WARM_RESET, RUNNING_FROM_LOADER} = 5'h0;
    PADDR = 8'h00;
    PWDATA = ZERO_WORD;
    BOOT_CONFIG_FIELD = 2'b11;
    DATA_REGION_FIXED_SIZE = 1'b1;
    CONFIG_WORD1 = 32'h0000_4a00;
    RST = 1'b1;
    reset_dut();
    for (int i = 0; i < 7; i++)
      rd_chk("reset value", 8'(4 * i), rst_val[i]);
    rd_chk("unmapped", 8'h28, ZERO_WORD);
    chk("unmapped err", {31'h0, er_q}, 32'h1);
    apb(1'b1, OFS_CONTROL, 32'h39);
    apb(1'b1, OFS_TIMING, 32'h50);
    rd_chk("locked control", OFS_CONTROL, ZERO_WORD);
    rd_chk("locked timing", OFS_TIMING, ZERO_WORD);
    run_op(cmdw(1'b1, FN_PROG), 32'h100, 32'h0, 1'b1);
    unlock();
    apb(1'b1, OFS_CONTROL, 32'h39);
    rd_chk("fail kept", OFS_CONTROL, 32'h79);
    run_op(cmdw(1'b1, FN_PROG), 32'h100, 32'ha5a5_1234, 1'b0);
    run_op(cmdw(1'b0, FN_READ), 32'h100, 32'h0, 1'b0);
    rd_chk("read back", OFS_DATA, 32'ha5a5_1234);
    rd_chk("fail not overwritten", OFS_CONTROL, 32'h79);
    apb(1'b1, OFS_CONTROL, 32'h79);
    rd_chk("fail cleared", OFS_CONTROL, 32'h39);
    run_op(cmdw(1'b1, FN_ERASE), 32'h100, 32'h0, 1'b0);
    run_op(cmdw(1'b0, FN_READ), 32'h100, 32'h0, 1'b0);
    rd_chk("erased", OFS_DATA, ERASE_WORD);
    for (int i = 0; i < 3; i++)
    begin
      run_op(cmdw(1'b0, FN_UID), 32'(4 * i), 32'h0, 1'b0);
      rd_chk("uid", OFS_DATA, UID_SEED + 32'(4 * i));
    end
    run_op(cmdw(1'b0, FN_UID), 32'h0c, 32'h0, 1'b1);
    apb(1'b1, OFS_CONTROL, 32'h79);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, OFS_CONTROL, bad_ctl[i]);
      RUNNING_FROM_LOADER <= (i == 2);
      run_op(cmdw(1'b1, FN_PROG), bad_adr[i], 32'h0, 1'b1);
      rd_chk("region fail", OFS_CONTROL, bad_ctl[i] | 32'h40);
      apb(1'b1, OFS_CONTROL, bad_ctl[i] | 32'h40);
    end
    apb(1'b1, OFS_CONTROL, 32'h39);
    run_op(cmdw(1'b1, FN_PROG), 32'h0030_0004, 32'h1234_5678, 1'b0);
    run_op(cmdw(1'b0, FN_READ), 32'h0030_0004, 32'h0, 1'b0);
    rd_chk("config word", OFS_DATA, 32'h1234_5678);
    run_op(cmdw(1'b0, FN_READ), 32'h0000_0004, 32'h0, 1'b0);
    rd_chk("main word", OFS_DATA, ERASE_WORD);
    rd_chk("irq status", OFS_IRQ_STAT, 32'h3);
    chk("irq masked", {31'h0, IRQ}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h2);
    settle();
    chk("irq fail", {31'h0, IRQ}, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h2);
    settle();
    chk("irq fail clear", {31'h0, IRQ}, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    settle();
    chk("irq done", {31'h0, IRQ}, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    rd_chk("irq status clear", OFS_IRQ_STAT, ZERO_WORD);
    chk("irq done clear", {31'h0, IRQ}, 32'h0);
    apb(1'b1, OFS_TIMING, 32'hff);
    rd_chk("timing", OFS_TIMING, 32'h50);
    DATA_REGION_FIXED_SIZE <= 1'b0;
    apb(1'b1, OFS_DR_BASE, ZERO_WORD);
    settle();
    rd_chk("base from config", OFS_DR_BASE, 32'h0000_4a00);
    BOOT_CONFIG_FIELD <= 2'b01;
    reset_dut();
    rd_chk("boot select cold", OFS_CONTROL, 32'h2);
    unlock();
    apb(1'b1, OFS_CONTROL, 32'h0000_0003);
    BOOT_CONFIG_FIELD <= 2'b11;
    WARM_RESET <= 1'b1;
    reset_dut();
    rd_chk("boot select warm", OFS_CONTROL, 32'h2);
    final_report();
  end

  // A hang ends the run through the same closing task.
  initial
  begin
    #100us;
    err_count++;
    final_report();
  end
endmodule
